/* inc/rws_pkg.sv */
// package: timing constants and state codes for the reset watchdog supervisor
package rws_pkg;
  // ****************************************
  // clock rates
  // ****************************************
  localparam int unsigned SYS_CLK_HZ = 50_000_000;
  localparam int unsigned XTAL_HZ = 19_660_800;
  localparam int unsigned MASTER_HZ = 9_830_400;
  // ****************************************
  // times and derived cycle counts
  // ****************************************
  localparam int unsigned RESET_PULSE_MS = 200;
  localparam int unsigned WDOG_TIMEOUT_MS = 1600;
  localparam int unsigned RESET_PULSE_CYC = (SYS_CLK_HZ / 1000) * RESET_PULSE_MS;
  localparam int unsigned WDOG_TIMEOUT_CYC = (SYS_CLK_HZ / 1000) * WDOG_TIMEOUT_MS;
  // ****************************************
  // values after reset
  // ****************************************
  localparam logic RESET_OUT_INIT = 1'b1;
  localparam logic [1:0] DIV_INIT = 2'h0;
  // ****************************************
  // supervisor states
  // ****************************************
  typedef enum logic [1:0] {
    RWS_PULSE = 2'b01,
    RWS_RUN = 2'b10
  } rws_state_t;
endpackage

/* rtl/rws_clkdiv.sv */
// module: board master clock and counter channel tick generator
`timescale 1ns/1ps
`default_nettype none
module rws_clkdiv (
  input wire logic xtal_clk_in,
  input wire logic arst_n_in,
  output logic master_clk_out,
  output logic ctc_tick_out
);
  logic [1:0] div;
  always_ff @(posedge xtal_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div <= rws_pkg::DIV_INIT;
    end else begin
      div <= div + 2'h1;
    end
  end
  // master = xtal/2, tick = master/2; both from flops
  always_ff @(posedge xtal_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      master_clk_out <= 1'b0;
      ctc_tick_out <= 1'b0;
    end else begin
      master_clk_out <= ~div[0];
      ctc_tick_out <= (div == 2'h3);
    end
  end
endmodule
`default_nettype wire

/* rtl/rws_supervisor.sv */
// module: reset supervisor with pulse stretcher, own watchdog and merged requests
//
// Functional notes
// - 200 ms reset pulse at power-on and on manual reset request.
// - own watchdog with 1.6 s timeout; expiry generates a reset.
// - also reset when processor or signal-processor watchdog requests.
// - master clock is crystal frequency halved, fed to all processors.
// - counter_timer_channel tick runs at half master clock.
`timescale 1ns/1ps
`default_nettype none
module rws_supervisor #(
  parameter int unsigned PULSE_CYC = rws_pkg::RESET_PULSE_CYC,
  parameter int unsigned WDOG_CYC = rws_pkg::WDOG_TIMEOUT_CYC
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic xtal_clk_in,
  input wire logic manual_rst_n_in,
  input wire logic cpu_wdog_req_in,
  input wire logic dsp_wdog_pulse_in,
  input wire logic wdog_service_in,
  output logic board_rst_out,
  output logic wdog_expired_out,
  output logic master_clk_out,
  output logic ctc_tick_out
);
  // ****************************************
  // registers: service history, counters and state
  // ****************************************
  logic svc_prev;
  logic [31:0] pulse_cnt;
  logic [31:0] wdog_cnt;
  rws_pkg::rws_state_t state;

  // ****************************************
  // state decode
  // ****************************************
  // is_run used by the watchdog counter and by the checks below, is_pulse by the checks only
  function automatic logic is_run(input rws_pkg::rws_state_t st);
    return st == rws_pkg::RWS_RUN;
  endfunction

  function automatic logic is_pulse(input rws_pkg::rws_state_t st);
    return st == rws_pkg::RWS_PULSE;
  endfunction

  wire service_edge = wdog_service_in ^ svc_prev;
  wire wdog_expire = is_run(state) && (wdog_cnt == 32'h0000_0000);
  // either external source restarts the pulse, as does manual and expiry
  wire any_req = !manual_rst_n_in || cpu_wdog_req_in || dsp_wdog_pulse_in || wdog_expire;
  wire pulse_done = (pulse_cnt == 32'h0000_0001);

  // ****************************************
  // state and counters
  // ****************************************
  // power-on: async reset lands in pulse state with full count
  // same length as a requested pulse, so one parameter sets both
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= rws_pkg::RWS_PULSE;
      pulse_cnt <= 32'(PULSE_CYC);
    end else if (any_req) begin
      state <= rws_pkg::RWS_PULSE;
      pulse_cnt <= PULSE_CYC;
    end else begin
      case (state)
        rws_pkg::RWS_PULSE: begin
          if (pulse_done) begin
            state <= rws_pkg::RWS_RUN;
          end
          pulse_cnt <= pulse_cnt - 32'h0000_0001;
        end
        default: begin
          state <= rws_pkg::RWS_RUN;
        end
      endcase
    end
  end

  // watchdog held reloaded while the board is in reset
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wdog_cnt <= 32'(WDOG_CYC);
      svc_prev <= 1'b0;
    end else begin
      svc_prev <= wdog_service_in;
      if (!is_run(state) || service_edge) begin
        wdog_cnt <= 32'(WDOG_CYC);
      end else if (wdog_cnt != 32'h0000_0000) begin
        wdog_cnt <= wdog_cnt - 32'h0000_0001;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      board_rst_out <= rws_pkg::RESET_OUT_INIT;
      wdog_expired_out <= 1'b0;
    end else begin
      board_rst_out <= any_req || (state == rws_pkg::RWS_PULSE && !pulse_done);
      wdog_expired_out <= wdog_expire;
    end
  end

  rws_clkdiv u_clkdiv (
    .xtal_clk_in(xtal_clk_in),
    .arst_n_in(arst_n_in),
    .master_clk_out(master_clk_out),
    .ctc_tick_out(ctc_tick_out)
  );

  // ****************************************
  // assertions
  // ****************************************
  sequence s_req;
    any_req;
  endsequence
  property p_req_resets;
    @(posedge sys_clk_in) disable iff (!arst_n_in) s_req |=> board_rst_out;
  endproperty
  a_req_resets: assert property (p_req_resets) else $error("request did not assert reset");
  property p_expire_resets;
    @(posedge sys_clk_in) disable iff (!arst_n_in) wdog_expire |=> board_rst_out && wdog_expired_out;
  endproperty
  a_expire_resets: assert property (p_expire_resets) else $error("expiry did not reset");
  property p_service_reload;
    @(posedge sys_clk_in) disable iff (!arst_n_in) service_edge |=> wdog_cnt == WDOG_CYC;
  endproperty
  a_service_reload: assert property (p_service_reload) else $error("service toggle did not reload");
  property p_pulse_min;
    @(posedge sys_clk_in) disable iff (!arst_n_in) $fell(any_req) |-> board_rst_out [*2];
  endproperty
  a_pulse_min: assert property (p_pulse_min) else $error("reset pulse too short");

  // ****************************************
  // pulse stretcher checks
  // ****************************************
  sequence s_pulse_last;
    is_pulse(state) && pulse_done && !any_req;
  endsequence

  sequence s_released;
    !board_rst_out && is_run(state);
  endsequence

  property p_pulse_end;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      s_pulse_last |=> s_released;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("reset pulse did not end");

  property p_pulse_hold;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      is_pulse(state) && !pulse_done |=> board_rst_out;
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("reset dropped inside pulse");

  property p_state_onehot;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      $onehot(state);
  endproperty
  a_state_onehot: assert property (p_state_onehot) else $error("state code not one-hot");

  property p_run_quiet;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      is_run(state) && !any_req |=> !board_rst_out;
  endproperty
  a_run_quiet: assert property (p_run_quiet) else $error("reset raised with no request");

  // ****************************************
  // watchdog checks
  // ****************************************
  property p_expire_single;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      wdog_expired_out |=> !wdog_expired_out;
  endproperty
  a_expire_single: assert property (p_expire_single) else $error("expiry flag longer than one cycle");

  // toggles during reset must not shorten the next period
  property p_held_full;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      !is_run(state) |=> wdog_cnt == WDOG_CYC;
  endproperty
  a_held_full: assert property (p_held_full) else $error("watchdog not held full in reset");

  property p_count_down;
    @(posedge sys_clk_in) disable iff (!arst_n_in)
      is_run(state) && !service_edge && (wdog_cnt != 32'h0000_0000)
        |=> wdog_cnt == $past(wdog_cnt) - 32'h0000_0001;
  endproperty
  a_count_down: assert property (p_count_down) else $error("watchdog did not count down");

  // ****************************************
  // crystal domain checks
  // ****************************************
  // clocked by the crystal, not the system clock, as the divider is
  property p_master_rise;
    @(posedge xtal_clk_in) disable iff (!arst_n_in)
      !master_clk_out |=> master_clk_out;
  endproperty
  a_master_rise: assert property (p_master_rise) else $error("master clock did not rise");

  property p_master_fall;
    @(posedge xtal_clk_in) disable iff (!arst_n_in)
      master_clk_out |=> !master_clk_out;
  endproperty
  a_master_fall: assert property (p_master_fall) else $error("master clock did not fall");

  property p_tick_gap;
    @(posedge xtal_clk_in) disable iff (!arst_n_in)
      ctc_tick_out |=> !ctc_tick_out [*3];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("channel tick spacing wrong");
endmodule
`default_nettype wire

/* tb/rws_src_model.sv */
// partner model: processor and signal-processor watchdog requesters
`timescale 1ns/1ps
`default_nettype none
module rws_src_model (
  input wire logic clk_in,
  output logic cpu_req_out,
  output logic dsp_pulse_out
);
  initial begin
    cpu_req_out = 1'b0;
    dsp_pulse_out = 1'b0;
  end
  // two lines kept apart, never merged here
  task automatic fire(input bit dsp, input int len);
    @(negedge clk_in);
    if (dsp)
      dsp_pulse_out = 1'b1;
    else
      cpu_req_out = 1'b1;
    repeat (len) @(negedge clk_in);
    cpu_req_out = 1'b0;
    dsp_pulse_out = 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// testbench: reset supervisor checked against a queue of pulse lengths
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int PC = 8;
  localparam int WC = 20;
  logic clk = 1'b0, xclk = 1'b0, rst_n = 1'b0, man_n = 1'b1, svc = 1'b0;
  logic cpu, dsp, brst, wexp, mclk, tick, prev_m;
  int n_errors = 0, checked = 0, cnt = 0, nexp = 0, tog = 0, nt = 0, seed = 27372;
  int q[$];
  always #10 clk = ~clk;
  always #25.431 xclk = ~xclk;
  rws_src_model rws_src_model_inst (.clk_in(clk), .cpu_req_out(cpu), .dsp_pulse_out(dsp));
  rws_supervisor #(.PULSE_CYC(PC), .WDOG_CYC(WC)) rws_supervisor_inst (.sys_clk_in(clk), .arst_n_in(rst_n),
    .xtal_clk_in(xclk), .manual_rst_n_in(man_n), .cpu_wdog_req_in(cpu), .dsp_wdog_pulse_in(dsp),
    .wdog_service_in(svc), .board_rst_out(brst), .wdog_expired_out(wexp), .master_clk_out(mclk),
    .ctc_tick_out(tick));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
      n_errors++;
    if (seen !== exp)
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
  endtask
  task automatic print_verdict();
    $display("counts: %0d compared, %0d mismatches", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // stand length counted from the last cycle any request was seen
  always @(posedge clk) begin
    if (wexp === 1'b1)
      nexp++;
    if (!man_n || cpu || dsp || !rst_n)
      cnt = 0;
    else if (brst === 1'b1)
      cnt++;
    else if (cnt != 0) begin
      if (q.size() > 0)
        check(cnt, q.pop_front());
      cnt = 0;
    end
  end
  always @(posedge xclk) begin
    if (mclk !== prev_m)
      tog++;
    prev_m = mclk;
    if (tick === 1'b1)
      nt++;
  end
  task automatic req(input int kind, input int len);
    q.push_back(PC);
    if (kind == 0) begin
      @(negedge clk);
      man_n = 1'b0;
      repeat (len) @(negedge clk);
      man_n = 1'b1;
    end else
      rws_src_model_inst.fire(kind == 2, len);
    repeat (PC + 4) @(negedge clk);
    $display("test done: request kind %0d", kind);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    q.push_back(PC);
    repeat (PC + 4) @(negedge clk);
    $display("test done: power-on");
    for (int k = 0; k < 6; k++)
      req(k % 3, 1 + ($unsigned($random(seed)) % 5));
    repeat (6) begin
      repeat (WC / 2) @(negedge clk);
      svc = ~svc;
    end
    check(nexp, 0);
    q.push_back(PC);
    repeat (WC + 4) @(negedge clk);
    check(nexp, 1);
    $display("test done: watchdog");
    @(negedge xclk);
    tog = 0;
    nt = 0;
    repeat (40) @(negedge xclk);
    check(tog, 40);
    check(nt, 10);
    $display("test done: clocks");
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
